// >>> hw/icm_master.sv
`timescale 1ns/10ps
`default_nettype none
module icm_master
  import icm_pkg::*;
(
  input wire logic ref_clk, // 25 MHz reference clock
  input wire logic resetn, // Async reset, active low
  input wire logic module_on, // Peripheral enable
  input wire logic fast_mode, // 1 selects the fast bus rate
  input wire logic addr10_mode, // 1 selects 10-bit addressing
  input wire logic [9:0] target_addr, // Target address
  input wire logic dir_read, // 1 reads from the target
  input wire logic event_irq_enable, // Gates event_irq
  input wire logic start_req, // Pulse: request a start
  input wire logic stop_req, // Pulse: request a stop
  input wire logic dr_write, // Pulse: data register write
  input wire logic [7:0] dr_wdata, // Data register write value
  input wire logic rd_status_one, // Pulse: status_reg_one read
  input wire logic rd_status_two, // Pulse: status_reg_two read
  input wire logic scl_in, // Clock line level
  input wire logic sda_in, // Data line level
  output logic scl_out, // Clock line drive value
  output logic scl_oe_n, // Low while pulling clock low
  output logic sda_out, // Data line drive value
  output logic sda_oe_n, // Low while pulling data low
  output icm_status_t status, // Flags and mode bits
  output icm_role_t role, // Present bus role
  output logic event_irq // Event interrupt request
);

  icm_state_t state;
  icm_byte_t kind;
  logic [1:0] q;
  logic [2:0] bit_cnt;
  logic [7:0] shifter;
  logic tick;
  logic [1:0] lines;
  logic scl_d;
  logic sda_d;
  logic start_pend;
  logic stop_pend;
  logic restart_pend;
  logic restart_rd;
  logic addressed;
  logic sr1_seen;
  logic addr_arm;
  logic ev_sb;
  logic ev_hdr;
  logic ev_addr;
  logic ev_arb;
  logic ev_nack;
  logic ev_slave;
  icm_status_t next_status;

  icm_pin_sync icm_pin_sync_inst (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .pin_raw({scl_in, sda_in}),
    .pin_level(lines)
  );

  icm_tick_gen icm_tick_gen_inst (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .fast_mode(fast_mode),
    .tick(tick)
  );

  // Line decode; the last quarter waits for a stretched clock to rise
  wire scl_s = lines[1];
  wire sda_s = lines[0];
  wire start_det = scl_s & scl_d & sda_d & ~sda_s;
  wire stop_det = scl_s & scl_d & ~sda_d & sda_s;
  wire step = tick & ((q != Q_LAST) | scl_s);
  wire hold = (state == ST_HOLD);
  wire go_stop = hold & stop_pend;
  wire go_restart = hold & ~go_stop
    & (start_pend | (restart_pend & ~status.addr_done_flag));
  wire busy_free = ~go_stop & ~go_restart & dr_write & sr1_seen;
  wire load_first = hold & busy_free & status.start_sent_flag;
  wire load_second = hold & busy_free & status.header_sent_flag;
  wire load_data = hold & ~go_stop & ~go_restart & dr_write
    & addressed & (role == ROLE_MST_TX) & ~status.addr_done_flag
    & ~status.header_sent_flag & ~status.start_sent_flag;
  wire [7:0] addr7_byte = {target_addr[6:0], dir_read};
  wire [7:0] hdr_byte = icm_header(target_addr,
    restart_rd ? DIR_READ : DIR_WRITE);
  wire [7:0] addr2_byte = target_addr[7:0];
  wire nack = sda_s;

  // Previous line levels for start and stop detection
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      scl_d <= 1'h1;
      sda_d <= 1'h1;
    end
    else
    begin
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end

  // Requests wait here until the engine can act on them
  // start needs module on
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      start_pend <= 1'h0;
      stop_pend <= 1'h0;
    end
    else
    begin
      if (start_req & module_on)
        start_pend <= 1'h1;
      else if ((state == ST_START) | ~module_on)
        start_pend <= 1'h0;
      if (stop_req & status.master_flag)
        stop_pend <= 1'h1;
      else if (state == ST_IDLE)
        stop_pend <= 1'h0;
    end
  end

  // Bit engine: four quarters per bit, lines only pulled or released
  // open drain drive
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state <= ST_IDLE;
      kind <= BY_DATA;
      q <= 2'h0;
      bit_cnt <= 3'h0;
      shifter <= 8'h00;
      scl_oe_n <= 1'h1;
      sda_oe_n <= 1'h1;
      scl_out <= 1'h0;
      sda_out <= 1'h0;
      role <= ROLE_SLV_RX;
      restart_pend <= 1'h0;
      restart_rd <= 1'h0;
      addressed <= 1'h0;
      ev_sb <= 1'h0;
      ev_hdr <= 1'h0;
      ev_addr <= 1'h0;
      ev_arb <= 1'h0;
      ev_nack <= 1'h0;
      ev_slave <= 1'h0;
    end
    else
    begin
      ev_sb <= 1'h0;
      ev_hdr <= 1'h0;
      ev_addr <= 1'h0;
      ev_arb <= 1'h0;
      ev_nack <= 1'h0;
      ev_slave <= 1'h0;
      if ((state != ST_IDLE) & (state != ST_HOLD) & step)
        q <= q + 2'h1;
      case (state)
        ST_IDLE:
        begin
          if (start_pend & module_on & ~status.bus_busy)
          begin
            state <= ST_START;
            q <= 2'h0;
          end
        end
        ST_START:
        begin
          if (step)
          begin
            case (q)
              2'h0: sda_oe_n <= 1'h1;
              2'h1: scl_oe_n <= 1'h1;
              2'h2: sda_oe_n <= 1'h0;
              default:
              begin
                scl_oe_n <= 1'h0;
                ev_sb <= 1'h1;
                addressed <= 1'h0;
                role <= ROLE_MST_TX;
                state <= ST_HOLD;
              end
            endcase
          end
        end
        ST_HOLD:
        begin
          // Clock is held low while software works
          q <= 2'h0;
          bit_cnt <= 3'h0;
          if (go_stop)
            state <= ST_STOP;
          else if (go_restart)
          begin
            restart_rd <= restart_pend;
            restart_pend <= 1'h0;
            state <= ST_START;
          end
          else if (load_first)
          begin
            shifter <= (addr10_mode | restart_rd) ? hdr_byte : addr7_byte;
            kind <= restart_rd ? BY_HDR_RD
              : (addr10_mode ? BY_HDR : BY_ADDR7);
            state <= ST_BIT;
          end
          else if (load_second)
          begin
            shifter <= addr2_byte;
            kind <= BY_ADDR2;
            state <= ST_BIT;
          end
          else if (load_data)
          begin
            shifter <= dr_wdata;
            kind <= BY_DATA;
            state <= ST_BIT;
          end
        end
        ST_BIT:
        begin
          if (step)
          begin
            case (q)
              2'h0:
              begin
                scl_oe_n <= 1'h0;
                sda_oe_n <= shifter[7];
              end
              2'h1: scl_oe_n <= 1'h0;
              2'h2: scl_oe_n <= 1'h1;
              default:
              begin
                if (shifter[7] & ~sda_s)
                begin
                  scl_oe_n <= 1'h1;
                  sda_oe_n <= 1'h1;
                  role <= ROLE_SLV_RX;
                  restart_pend <= 1'h0;
                  restart_rd <= 1'h0;
                  ev_arb <= 1'h1;
                  ev_slave <= 1'h1;
                  state <= ST_IDLE;
                end
                else
                begin
                  shifter <= {shifter[6:0], 1'h0};
                  bit_cnt <= bit_cnt + 3'h1;
                  if (bit_cnt == LAST_BIT)
                    state <= ST_ACK;
                end
              end
            endcase
          end
        end
        ST_ACK:
        begin
          // A second q0 pass ends the ack clock after a full high half
          if (step)
          begin
            case (q)
              2'h0:
              begin
                scl_oe_n <= 1'h0;
                sda_oe_n <= 1'h1;
                if (bit_cnt != 3'h0)
                begin
                  state <= ST_HOLD;
                  if (kind == BY_HDR)
                    ev_hdr <= 1'h1;
                  else if (kind != BY_DATA)
                  begin
                    ev_addr <= 1'h1;
                    addressed <= 1'h1;
                    restart_rd <= 1'h0;
                    restart_pend <= (kind == BY_ADDR2) & dir_read;
                    role <= ((kind == BY_HDR_RD)
                      | ((kind == BY_ADDR7) & dir_read))
                      ? ROLE_MST_RX : ROLE_MST_TX;
                  end
                end
              end
              2'h1: scl_oe_n <= 1'h0;
              2'h2: scl_oe_n <= 1'h1;
              default:
              begin
                if (nack)
                begin
                  ev_nack <= 1'h1;
                  state <= ST_STOP;
                end
                else
                  bit_cnt <= 3'h1;
              end
            endcase
          end
        end
        ST_STOP:
        begin
          if (step)
          begin
            case (q)
              // Clock low first, so data never falls while clock is high
              2'h0: scl_oe_n <= 1'h0;
              2'h1: sda_oe_n <= 1'h0;
              2'h2: scl_oe_n <= 1'h1;
              default:
              begin
                sda_oe_n <= 1'h1;
                role <= ROLE_SLV_RX;
                restart_pend <= 1'h0;
                restart_rd <= 1'h0;
                ev_slave <= 1'h1;
                state <= ST_IDLE;
              end
            endcase
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Read sequences that clear the flags; a set in the same cycle wins
  wire sr1_first = ~addr10_mode & rd_status_one;
  wire sr2_first = addr10_mode & rd_status_two;
  wire sr_second = addr10_mode ? rd_status_one : rd_status_two;
  wire clr_addr = addr_arm & sr_second;

  always_comb
  begin
    next_status = status;
    if (ev_sb)
      next_status.master_flag = 1'h1;
    else if (ev_slave)
      next_status.master_flag = 1'h0;
    next_status.start_sent_flag = (status.start_sent_flag & ~load_first)
      | ev_sb;
    next_status.header_sent_flag = (status.header_sent_flag & ~load_second)
      | ev_hdr;
    next_status.addr_done_flag = (status.addr_done_flag & ~clr_addr)
      | ev_addr;
    next_status.arb_lost = (status.arb_lost & ~rd_status_one) | ev_arb;
    next_status.ack_fail = (status.ack_fail & ~rd_status_one) | ev_nack;
    if (start_det)
      next_status.bus_busy = 1'h1;
    else if (stop_det)
      next_status.bus_busy = 1'h0;
  end

  // Flag registers and the interrupt line
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      status <= STATUS_RST;
      sr1_seen <= 1'h0;
      addr_arm <= 1'h0;
      event_irq <= 1'h0;
    end
    else
    begin
      status <= next_status;
      if (rd_status_one)
        sr1_seen <= 1'h1;
      else if (dr_write)
        sr1_seen <= 1'h0;
      if ((sr1_first | sr2_first) & status.addr_done_flag)
        addr_arm <= 1'h1;
      else if (clr_addr | ev_addr)
        addr_arm <= 1'h0;
      event_irq <= event_irq_enable & (next_status.start_sent_flag
        | next_status.header_sent_flag | next_status.addr_done_flag);
    end
  end

endmodule
`default_nettype wire

// >>> include/icm_pkg.sv
package icm_pkg;

  // Clock and bus timing, all derived from the 25 MHz reference
  localparam int CLK_PERIOD_NS = 40;
  localparam int STD_BIT_NS = 10000;
  localparam int FAST_BIT_NS = 2500;
  // A quarter bit is a least time, so it rounds up
  localparam int QTR_STD_CYC =
    (STD_BIT_NS / 4 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int QTR_FAST_CYC =
    (FAST_BIT_NS / 4 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int QTR_W = 7;

  // Byte layout on the wire
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [4:0] HDR_PATTERN = 5'h1E;
  localparam logic DIR_WRITE = 1'h0;
  localparam logic DIR_READ = 1'h1;
  localparam logic [1:0] Q_LAST = 2'h3;

  typedef enum logic [1:0] {
    ROLE_SLV_RX,
    ROLE_SLV_TX,
    ROLE_MST_TX,
    ROLE_MST_RX
  } icm_role_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_START,
    ST_HOLD,
    ST_BIT,
    ST_ACK,
    ST_STOP
  } icm_state_t;

  typedef enum logic [2:0] {
    BY_HDR,
    BY_ADDR2,
    BY_ADDR7,
    BY_HDR_RD,
    BY_DATA
  } icm_byte_t;

  typedef struct packed {
    logic master_flag;
    logic start_sent_flag;
    logic header_sent_flag;
    logic addr_done_flag;
    logic arb_lost;
    logic ack_fail;
    logic bus_busy;
  } icm_status_t;

  localparam icm_status_t STATUS_RST = '0;

  // Header byte of a 10-bit address: fixed pattern, top bits, direction
  function automatic logic [7:0] icm_header(input logic [9:0] a,
                                            input logic dir);
    icm_header = {HDR_PATTERN, a[9:8], dir};
  endfunction

endpackage

// >>> hw/icm_pin_sync.sv
`timescale 1ns/10ps
`default_nettype none
module icm_pin_sync
  import icm_pkg::*;
(
  input wire logic ref_clk, // Reference clock
  input wire logic resetn, // Async reset, active low
  input wire logic [1:0] pin_raw, // Raw pin levels
  output logic [1:0] pin_level // Accepted levels
);

  // Three stages per pin; a change counts once stages two and three agree
  genvar i;
  generate
    for (i = 0; i < 2; i++)
    begin : g_pin
      logic s1;
      logic s2;
      logic s3;
      always_ff @(posedge ref_clk or negedge resetn)
      begin
        if (!resetn)
        begin
          s1 <= 1'h1;
          s2 <= 1'h1;
          s3 <= 1'h1;
          pin_level[i] <= 1'h1;
        end
        else
        begin
          s1 <= pin_raw[i];
          s2 <= s1;
          s3 <= s2;
          if (s2 == s3)
            pin_level[i] <= s3;
        end
      end
    end
  endgenerate

endmodule
`default_nettype wire

// >>> hw/icm_tick_gen.sv
`timescale 1ns/10ps
`default_nettype none
module icm_tick_gen
  import icm_pkg::*;
(
  input wire logic ref_clk, // Reference clock
  input wire logic resetn, // Async reset, active low
  input wire logic fast_mode, // 1 selects the fast bus rate
  output logic tick // One pulse per quarter bit
);

  logic [QTR_W-1:0] cnt;
  wire [QTR_W-1:0] limit;

  // Rate change takes effect at once; a count at or past the new limit wraps on the next cycle, mid-quarter
  assign limit = fast_mode ? QTR_W'(QTR_FAST_CYC - 1)
    : QTR_W'(QTR_STD_CYC - 1);

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cnt <= '0;
      tick <= 1'h0;
    end
    else
    begin
      tick <= (cnt >= limit);
      cnt <= (cnt >= limit) ? '0 : cnt + QTR_W'(1);
    end
  end

endmodule
`default_nettype wire

// >>> dv/icm_slave_model.sv
`timescale 1ns/10ps
`default_nettype none
module icm_slave_model
(
  input wire logic ref_clk, // Sampling clock
  input wire logic scl, // Clock line level
  input wire logic sda, // Data line level
  input wire logic nack, // 1 refuses every byte
  output logic sda_pull_n, // Low pulls data low
  output logic [7:0] last_byte, // Last byte taken
  output logic [7:0] byte_cnt, // Bytes taken
  output logic [7:0] start_cnt // Starts seen
);
  logic scl_q = 1'b1;
  logic sda_q = 1'b1;
  logic [3:0] bit_cnt = 4'h0;
  logic [7:0] shreg = 8'h00;
  initial
  begin
    sda_pull_n = 1'b1;
    {last_byte, byte_cnt, start_cnt} = 24'h000000;
  end
  // Lines sampled on the reference clock, so equal-time edges never race
  always @(posedge ref_clk)
  begin
    if (scl_q && scl && sda_q && !sda)
    begin
      bit_cnt = 4'h0;
      start_cnt = start_cnt + 8'h01;
    end
    else if (!scl_q && scl)
    begin
      if (bit_cnt == 4'h8)
        bit_cnt = 4'h0;
      else
      begin
        shreg = {shreg[6:0], sda};
        bit_cnt = bit_cnt + 4'h1;
        if (bit_cnt == 4'h8)
        begin
          last_byte = shreg;
          byte_cnt = byte_cnt + 8'h01;
        end
      end
    end
    if (scl_q && !scl)
      sda_pull_n = !(bit_cnt == 4'h8 && !nack);
    scl_q = scl;
    sda_q = sda;
  end
endmodule
`default_nettype wire

// >>> dv/icm_master_chk.sv
`timescale 1ns/10ps
`default_nettype none
module icm_master_chk
  import icm_pkg::*;
(
  input wire logic ref_clk, // Clock
  input wire logic resetn, // Reset, active low
  input wire logic fast_mode, // Rate select
  input wire logic addr10_mode, // Address width
  input wire logic dr_write, // Data write pulse
  input wire logic rd_status_one, // Status one read
  input wire logic rd_status_two, // Status two read
  input wire logic event_irq_enable, // Irq gate
  input wire logic scl_out, // Clock drive value
  input wire logic sda_out, // Data drive value
  input wire logic scl_oe_n, // Clock pull, low active
  input wire logic sda_oe_n, // Data pull, low active
  input wire icm_status_t status, // Flags
  input wire icm_role_t role, // Role
  input wire logic event_irq // Event irq
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  localparam int MIN_S = 2 * QTR_STD_CYC - 1;
  localparam int MIN_F = 2 * QTR_FAST_CYC - 1;
  logic rd1_seen, rd2_seen, start_seen, sda_q;
  logic [7:0] hi_cnt;
  // Start and stop as seen from the drives; data moves only with SCL low
  wire logic start_cond = sda_q && !sda_oe_n && scl_oe_n;
  wire logic stop_cond = !sda_q && sda_oe_n && scl_oe_n;
  wire logic [7:0] next_hi = (hi_cnt == 8'hFF) ? hi_cnt : hi_cnt + 8'h01;
  // Read history; a data write opens a fresh sequence
  always_ff @(posedge ref_clk or negedge resetn)
    if (!resetn)
      {rd1_seen, rd2_seen} <= 2'h0;
    else if (dr_write)
      {rd1_seen, rd2_seen} <= 2'h0;
    else
      {rd1_seen, rd2_seen} <= {rd1_seen | rd_status_one,
                               rd2_seen | rd_status_two};
  // Drive history; high count saturates so idle time cannot wrap
  always_ff @(posedge ref_clk or negedge resetn)
    if (!resetn)
      {sda_q, start_seen, hi_cnt} <= {1'b1, 1'b0, 8'h00};
    else
      {sda_q, start_seen, hi_cnt} <= {sda_oe_n,
        start_cond | (start_seen & !stop_cond), scl_oe_n ? next_hi : 8'h00};
  AST_OPEN_DRAIN: assert property (!scl_out && !sda_out)
    else $error("line drive value not zero");
  AST_MASTER_AFTER_START: assert property (
    $rose(status.master_flag) |-> start_seen || start_cond)
    else $error("master without own start");
  AST_SLAVE_AFTER_STOP: assert property (
    status.master_flag && stop_cond
      |-> ##[0:4] (!status.master_flag && role == ROLE_SLV_RX))
    else $error("still master after stop");
  AST_IRQ_CAUSE: assert property (
    event_irq == ($past(event_irq_enable) && (status.start_sent_flag ||
      status.header_sent_flag || status.addr_done_flag)))
    else $error("event irq wrong");
  AST_SCL_HIGH_MIN: assert property (
    $fell(scl_oe_n) && status.master_flag
      |-> hi_cnt >= (fast_mode ? MIN_F : MIN_S))
    else $error("clock high too short");
  AST_START_SENT_CLEAR: assert property (
    status.start_sent_flag && dr_write && rd1_seen
      |-> ##[1:3] !status.start_sent_flag)
    else $error("start flag not cleared");
  AST_HEADER_CLEAR: assert property (
    status.header_sent_flag && dr_write && rd1_seen
      |-> ##[1:3] !status.header_sent_flag)
    else $error("header flag not cleared");
  AST_ADDR7_CLEAR: assert property (
    !addr10_mode && status.addr_done_flag && rd_status_two && rd1_seen
      |-> ##[1:3] !status.addr_done_flag)
    else $error("7-bit address flag not cleared");
  AST_ADDR10_CLEAR: assert property (
    addr10_mode && status.addr_done_flag && rd_status_one && rd2_seen
      |-> ##[1:3] !status.addr_done_flag)
    else $error("10-bit address flag not cleared");
endmodule
`default_nettype wire

// >>> dv/icm_master_tb.sv
`timescale 1ns/10ps
`default_nettype none
bind icm_master icm_master_chk icm_master_chk_inst (.ref_clk(ref_clk),
  .resetn(resetn), .fast_mode(fast_mode), .addr10_mode(addr10_mode),
  .dr_write(dr_write), .rd_status_one(rd_status_one),
  .rd_status_two(rd_status_two), .event_irq_enable(event_irq_enable),
  .scl_out(scl_out), .sda_out(sda_out), .scl_oe_n(scl_oe_n),
  .sda_oe_n(sda_oe_n), .status(status), .role(role), .event_irq(event_irq));
module icm_master_tb
  import icm_pkg::*;
;
  localparam int P_ST = 0, P_SP = 1, P_WR = 2, P_R1 = 3, P_R2 = 4;
  localparam int B_MST = 6, B_SB = 5, B_HDR = 4, B_AD = 3, B_AF = 1, B_BY = 7;
  logic ref_clk, resetn, module_on, fast_mode, addr10_mode, dir_read;
  logic event_irq_enable, start_req, stop_req, dr_write, nack;
  logic rd_status_one, rd_status_two, scl_out, scl_oe_n, sda_out, sda_oe_n;
  logic event_irq, sda_pull_n;
  logic [9:0] target_addr;
  logic [7:0] dr_wdata, last_byte, byte_cnt, start_cnt, s;
  icm_status_t status;
  icm_role_t role;
  int errors, checked;
  // Pull-ups: a released line reads high
  wire logic scl_w = scl_oe_n ? 1'b1 : scl_out;
  wire logic sda_w = (sda_oe_n ? 1'b1 : sda_out) & sda_pull_n;
  icm_master icm_master_inst (.ref_clk(ref_clk), .resetn(resetn),
    .module_on(module_on), .fast_mode(fast_mode), .addr10_mode(addr10_mode),
    .target_addr(target_addr), .dir_read(dir_read),
    .event_irq_enable(event_irq_enable), .start_req(start_req),
    .stop_req(stop_req), .dr_write(dr_write), .dr_wdata(dr_wdata),
    .rd_status_one(rd_status_one), .rd_status_two(rd_status_two),
    .scl_in(scl_w), .sda_in(sda_w), .scl_out(scl_out), .scl_oe_n(scl_oe_n),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .status(status), .role(role),
    .event_irq(event_irq));
  icm_slave_model icm_slave_model_inst (.ref_clk(ref_clk), .scl(scl_w),
    .sda(sda_w), .nack(nack), .sda_pull_n(sda_pull_n),
    .last_byte(last_byte), .byte_cnt(byte_cnt), .start_cnt(start_cnt));
  task wrap_up();
    $display("errors=%0d checked=%0d", errors, checked);
    if (errors == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task chk(input logic [9:0] got, input logic [9:0] exp, input string what);
    checked++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  function automatic logic [7:0] probe(input int b);
    probe = (b < B_BY) ? {7'h00, status[b]} : byte_cnt;
  endfunction
  // Bounded wait; running out ends the run
  task wait_on(input int b, input logic [7:0] v);
    int n;
    n = 0;
    while (probe(b) !== v && n < 6000)
    begin
      @(negedge ref_clk);
      n++;
    end
    chk(n < 6000, 1'b1, "wait bound");
    if (n >= 6000)
      wrap_up();
  endtask
  // One-cycle request, then a quiet cycle so pulses never merge
  task pulse(input int k, input logic [7:0] d);
    {start_req, stop_req, dr_write, rd_status_one, rd_status_two} = 5'h10 >> k;
    dr_wdata = d;
    @(negedge ref_clk);
    {start_req, stop_req, dr_write, rd_status_one, rd_status_two} = 5'h00;
    @(negedge ref_clk);
  endtask
  // Settings first, enable last, as software must
  task setup(input logic f, a10, input logic [9:0] a, input logic rd, ie);
    {fast_mode, addr10_mode, target_addr, dir_read} = {f, a10, a, rd};
    event_irq_enable = ie;
    module_on = 1'b1;
    @(negedge ref_clk);
  endtask
  // Start, then the first address write
  task go_start();
    pulse(P_ST, 8'h00);
    wait_on(B_SB, 8'h01);
    chk(status.master_flag, 1'b1, "master");
    pulse(P_R1, 8'h00);
    chk(event_irq, event_irq_enable, "irq");
    pulse(P_WR, 8'hFF);
    chk(status.start_sent_flag, 1'b0, "start flag");
  endtask
  task finish_stop();
    pulse(P_SP, 8'h00);
    wait_on(B_MST, 8'h00);
    chk(role, ROLE_SLV_RX, "role after stop");
  endtask
  task sc_reset();
    chk(status, STATUS_RST, "reset status");
    chk(role, ROLE_SLV_RX, "reset role");
    chk({scl_oe_n, sda_oe_n}, 2'h3, "reset lines");
  endtask
  task sc_seven_write();
    setup(1'b1, 1'b0, 10'h05A, DIR_WRITE, 1'b1);
    go_start();
    wait_on(B_AD, 8'h01);
    chk(last_byte, {target_addr[6:0], DIR_WRITE}, "addr7 w");
    pulse(P_R1, 8'h00);
    pulse(P_R2, 8'h00);
    chk(status.addr_done_flag, 1'b0, "addr done");
    chk(role, ROLE_MST_TX, "role tx");
    s = byte_cnt;
    pulse(P_R1, 8'h00);
    pulse(P_WR, 8'hC3);
    wait_on(B_BY, s + 8'h01);
    chk(last_byte, 8'hC3, "data");
    finish_stop();
  endtask
  task sc_seven_read_std();
    setup(1'b0, 1'b0, 10'h031, DIR_READ, 1'b0);
    go_start();
    wait_on(B_AD, 8'h01);
    chk(last_byte, {target_addr[6:0], DIR_READ}, "addr7 r");
    chk(role, ROLE_MST_RX, "role rx7");
    pulse(P_R1, 8'h00);
    pulse(P_R2, 8'h00);
    finish_stop();
  endtask
  task sc_ten_write();
    setup(1'b1, 1'b1, 10'h2A5, DIR_WRITE, 1'b1);
    go_start();
    wait_on(B_HDR, 8'h01);
    chk(last_byte, {HDR_PATTERN, 2'h2, DIR_WRITE}, "header");
    pulse(P_R1, 8'h00);
    pulse(P_WR, 8'hFF);
    chk(status.header_sent_flag, 1'b0, "header flag");
    wait_on(B_AD, 8'h01);
    chk(last_byte, 8'hA5, "low byte");
    pulse(P_R2, 8'h00);
    pulse(P_R1, 8'h00);
    chk(status.addr_done_flag, 1'b0, "addr done");
    s = start_cnt;
    pulse(P_R1, 8'h00);
    pulse(P_WR, 8'h3C);
    wait_on(B_BY, byte_cnt + 8'h01);
    chk(last_byte, 8'h3C, "data");
    chk(start_cnt, s, "no new start");
    finish_stop();
  endtask
  task sc_ten_read();
    setup(1'b1, 1'b1, 10'h1C3, DIR_READ, 1'b1);
    go_start();
    wait_on(B_HDR, 8'h01);
    chk(last_byte, {HDR_PATTERN, 2'h1, DIR_WRITE}, "header");
    pulse(P_R1, 8'h00);
    pulse(P_WR, 8'hFF);
    wait_on(B_AD, 8'h01);
    chk(last_byte, 8'hC3, "low byte");
    s = start_cnt;
    pulse(P_R2, 8'h00);
    pulse(P_R1, 8'h00);
    wait_on(B_SB, 8'h01);
    chk(start_cnt, s + 8'h01, "repeated start");
    pulse(P_R1, 8'h00);
    pulse(P_WR, 8'hFF);
    wait_on(B_AD, 8'h01);
    chk(last_byte, {HDR_PATTERN, 2'h1, DIR_READ}, "read header");
    chk(role, ROLE_MST_RX, "role rx");
    pulse(P_R2, 8'h00);
    pulse(P_R1, 8'h00);
    finish_stop();
  endtask
  task sc_nack();
    nack = 1'b1;
    setup(1'b1, 1'b0, 10'h07F, DIR_WRITE, 1'b1);
    go_start();
    wait_on(B_AF, 8'h01);
    wait_on(B_MST, 8'h00);
    chk(role, ROLE_SLV_RX, "role after refusal");
    nack = 1'b0;
    pulse(P_R1, 8'h00);
    chk(status.ack_fail, 1'b0, "fail flag");
  endtask
  // 25 MHz is above both minimum input clocks
  initial
  begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  initial
  begin
    {errors, checked, resetn, nack, target_addr, dr_wdata} = '0;
    {module_on, fast_mode, addr10_mode, dir_read, event_irq_enable} = 5'h00;
    {start_req, stop_req, dr_write, rd_status_one, rd_status_two} = 5'h00;
    repeat (10) @(negedge ref_clk);
    resetn = 1'b1;
    @(negedge ref_clk);
    sc_reset();
    sc_seven_write();
    sc_seven_read_std();
    sc_ten_write();
    sc_ten_read();
    sc_nack();
    wrap_up();
  end
endmodule
`default_nettype wire
